//--- sfio_frontend.v
`timescale 1ns/100ps
`include "sfio_defines.vh"
// serial flash pin front end: frames, lanes, hold, byte streams
module sfio_frontend (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire CS_N,
  input wire SCLK,
  input wire DATA_LANE_ZERO_IN,
  input wire DATA_LANE_ONE_IN,
  input wire DATA_LANE_TWO_IN,
  input wire DATA_LANE_THREE_IN,
  output reg DATA_LANE_ZERO_OUT,
  output reg DATA_LANE_ONE_OUT,
  output reg DATA_LANE_TWO_OUT,
  output reg DATA_LANE_THREE_OUT,
  output reg DATA_LANE_ZERO_OE,
  output reg DATA_LANE_ONE_OE,
  output reg DATA_LANE_TWO_OE,
  output reg DATA_LANE_THREE_OE,
  input wire QUAD_LANE_ENABLE_BIT,
  output reg [7:0] CMD_OPCODE,
  output reg [20:0] CMD_ADDR,
  output reg CMD_VALID,
  output reg FRAME_END,
  output reg SELECTED,
  input wire [7:0] RD_DATA,
  input wire RD_VALID,
  output reg RD_READY,
  output wire [7:0] WR_DATA,
  output wire WR_VALID,
  input wire WR_READY,
  output reg WR_OVERRUN
);
  // frame states
  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_ADDR = 3'd2;
  localparam ST_DUMMY = 3'd3;
  localparam ST_DIN = 3'd4;
  localparam ST_DOUT = 3'd5;
  localparam ST_IGNORE = 3'd6;

  // three-stage synchronisers for every pin input
  wire [5:0] pin_in = {CS_N, SCLK, DATA_LANE_THREE_IN, DATA_LANE_TWO_IN,
    DATA_LANE_ONE_IN, DATA_LANE_ZERO_IN};
  reg [5:0] s1; // first stage, read only by s2
  reg [5:0] s2; // second stage
  reg [5:0] s3; // third stage
  reg [5:0] filt; // accepted level once s2 and s3 agree

  wire [5:0] sync_rst = `SFIO_SYNC_RST; // reset level per pin
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      // per pin: shift, then accept when stages two and three agree
      always @(posedge CLK)
      begin
        if (!RST_N)
        begin
          s1[gi] <= sync_rst[gi];
          s2[gi] <= sync_rst[gi];
          s3[gi] <= sync_rst[gi];
          filt[gi] <= sync_rst[gi];
        end
        else if (CE)
        begin
          s1[gi] <= pin_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
          if (s2[gi] == s3[gi])
            filt[gi] <= s3[gi];
        end
      end
    end
  endgenerate

  // edge events on the agreed levels
  // cs reset level is low, so a select held low from power-up never
  // counts as a falling edge: the host must raise it first
  wire cs_fall = filt[5] & ~s2[5] & ~s3[5];
  wire cs_rise = ~filt[5] & s2[5] & s3[5];
  // both clock polarities at select time work: only edges matter
  wire clk_rise = ~filt[4] & s2[4] & s3[4];
  wire clk_fall = filt[4] & ~s2[4] & ~s3[4];
  wire [3:0] lane_s = s3[3:0]; // data lanes at the edge

  // frame state
  reg [2:0] state; // frame phase
  reg [5:0] cnt; // clocks within the phase
  reg [23:0] sh; // input shift register
  reg [7:0] opcode; // latched instruction
  reg is_read; // data phase drives out
  reg [1:0] aw; // address lane width
  reg [1:0] dw; // data lane width
  reg [5:0] dummy; // dummy clocks of this command
  reg [8:0] prog_cnt; // bytes taken in this program frame
  reg [7:0] obyte; // byte being shifted out
  reg [2:0] obit; // bit clocks left in obyte
  reg [7:0] rd_buf; // prefetched read byte
  reg rd_have; // rd_buf holds a byte
  reg [7:0] wr_pend; // assembled byte waiting for the fifo
  reg wr_pend_v; // wr_pend is valid
  reg driving; // first falling edge seen in data out

  // hold pauses the frame; lane three is data under quad enable
  wire hold_act = ~QUAD_LANE_ENABLE_BIT & ~filt[3] & ~filt[5];
  wire go_rise = clk_rise & ~hold_act;
  wire go_fall = clk_fall & ~hold_act;

  // opcode classification: {rd, addr, aw, dw, dummy, quad}
  reg [12:0] dec;
  always @*
  begin
    case (opcode_next_val(sh[6:0], lane_s[0]))
      `SFIO_OP_READ: dec = {1'b1, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_NONE, 1'b0};
      `SFIO_OP_FAST_READ: dec = {1'b1, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_FAST, 1'b0};
      `SFIO_OP_DUAL_OUT: dec = {1'b1, 1'b1, `SFIO_W_SINGLE, `SFIO_W_DUAL,
        `SFIO_DUMMY_FAST, 1'b0};
      `SFIO_OP_QUAD_OUT: dec = {1'b1, 1'b1, `SFIO_W_SINGLE, `SFIO_W_QUAD,
        `SFIO_DUMMY_FAST, 1'b1};
      `SFIO_OP_DUAL_IO: dec = {1'b1, 1'b1, `SFIO_W_DUAL, `SFIO_W_DUAL,
        `SFIO_DUMMY_DUAL_IO, 1'b0};
      `SFIO_OP_QUAD_IO: dec = {1'b1, 1'b1, `SFIO_W_QUAD, `SFIO_W_QUAD,
        `SFIO_DUMMY_QUAD_IO, 1'b1};
      `SFIO_OP_PROGRAM: dec = {1'b0, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_NONE, 1'b0};
      `SFIO_OP_QUAD_PROGRAM: dec = {1'b0, 1'b1, `SFIO_W_SINGLE, `SFIO_W_QUAD,
        `SFIO_DUMMY_NONE, 1'b1};
      `SFIO_OP_ERASE_4K, `SFIO_OP_ERASE_32K, `SFIO_OP_ERASE_64K:
        dec = {1'b0, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
          `SFIO_DUMMY_NONE, 1'b0};
      // unique id: no address, 32 dummy clocks, then 64 id bits
      `SFIO_OP_UNIQUE_ID: dec = {1'b1, 1'b0, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_UID, 1'b0};
      // security areas are addressed like the array
      `SFIO_OP_SEC_READ: dec = {1'b1, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_FAST, 1'b0};
      `SFIO_OP_SEC_PROGRAM: dec = {1'b0, 1'b1, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_NONE, 1'b0};
      `SFIO_OP_STATUS_1, `SFIO_OP_STATUS_2, `SFIO_OP_STATUS_3,
      `SFIO_OP_JEDEC_ID:
        dec = {1'b1, 1'b0, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
          `SFIO_DUMMY_NONE, 1'b0};
      // anything else: single-lane bytes in, passed to the core
      default: dec = {1'b0, 1'b0, `SFIO_W_SINGLE, `SFIO_W_SINGLE,
        `SFIO_DUMMY_NONE, 1'b0};
    endcase
  end

  // opcode as it completes on the eighth rising edge
  function [7:0] opcode_next_val;
    input [6:0] prev;
    input bit0;
    begin
      opcode_next_val = {prev, bit0};
    end
  endfunction

  // shift in one clock worth of lanes at the given width
  function [23:0] shift_in;
    input [23:0] cur;
    input [1:0] w;
    input [3:0] l;
    begin
      case (w)
        `SFIO_W_DUAL: shift_in = {cur[21:0], l[1:0]};
        `SFIO_W_QUAD: shift_in = {cur[19:0], l[3:0]};
        default: shift_in = {cur[22:0], l[0]};
      endcase
    end
  endfunction

  // last clock index of a phase of n bits at width w
  function [5:0] last_clk;
    input [5:0] nbits;
    input [1:0] w;
    begin
      last_clk = (nbits >> w) - 6'd1;
    end
  endfunction

  // erase granularity trims the address to the erased unit
  function [20:0] erase_mask;
    input [7:0] op;
    begin
      case (op)
        `SFIO_OP_ERASE_4K: erase_mask = `SFIO_MASK_4K;
        `SFIO_OP_ERASE_32K: erase_mask = `SFIO_MASK_32K;
        `SFIO_OP_ERASE_64K: erase_mask = `SFIO_MASK_64K;
        default: erase_mask = {`SFIO_ADDR_W{1'b1}};
      endcase
    end
  endfunction

  wire is_program = (opcode == `SFIO_OP_PROGRAM) ||
    (opcode == `SFIO_OP_QUAD_PROGRAM) || (opcode == `SFIO_OP_SEC_PROGRAM);
  wire [23:0] sh_next = shift_in(sh, (state == ST_ADDR) ? aw : dw, lane_s);
  wire [5:0] data_last = last_clk(6'd8, dw); // last clock of a byte
  wire byte_out_need = (obit == 3'd0);
  wire [7:0] fill_byte = rd_have ? rd_buf : `SFIO_IDLE_BYTE;
  wire [7:0] cur_byte = byte_out_need ? fill_byte : obyte;

  // the fifo stalls hand-over; a second byte landing while one still
  // waits replaces it and the waiting byte is lost, since the serial host itself cannot be stalled
  wire fifo_in_ready;

  // frame sequencer
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state <= ST_IDLE;
      cnt <= 6'd0;
      sh <= 24'h000000;
      opcode <= 8'h00;
      is_read <= 1'b0;
      aw <= `SFIO_W_SINGLE;
      dw <= `SFIO_W_SINGLE;
      dummy <= 6'd0;
      prog_cnt <= 9'h000;
      obyte <= 8'h00;
      obit <= 3'd0;
      rd_buf <= 8'h00;
      rd_have <= 1'b0;
      wr_pend <= 8'h00;
      wr_pend_v <= 1'b0;
      driving <= 1'b0;
      CMD_OPCODE <= 8'h00;
      CMD_ADDR <= 21'h000000;
      CMD_VALID <= 1'b0;
      FRAME_END <= 1'b0;
      SELECTED <= 1'b0;
      RD_READY <= 1'b0;
      WR_OVERRUN <= 1'b0;
    end
    else if (CE)
    begin
      CMD_VALID <= 1'b0;
      FRAME_END <= 1'b0;
      // pending write byte leaves as soon as the fifo has room
      if (wr_pend_v && fifo_in_ready)
        wr_pend_v <= 1'b0;
      // read prefetch from the core
      if (RD_READY && RD_VALID)
      begin
        rd_buf <= RD_DATA;
        rd_have <= 1'b1;
      end
      RD_READY <= (state == ST_DOUT) && !rd_have && !(RD_READY && RD_VALID);
      if (cs_rise)
      begin
        // deselect ends the frame only; the core keeps running any cycle
        state <= ST_IDLE;
        SELECTED <= 1'b0;
        driving <= 1'b0;
        FRAME_END <= (state != ST_IDLE);
      end
      else if (cs_fall)
      begin
        // only a falling select opens a frame
        state <= ST_CMD;
        SELECTED <= 1'b1;
        cnt <= 6'd0;
        prog_cnt <= 9'h000;
        obit <= 3'd0;
        driving <= 1'b0;
        rd_have <= 1'b0;
        WR_OVERRUN <= 1'b0;
      end
      else if (go_rise)
      begin
        case (state)
          ST_CMD:
          begin
            // instruction always arrives on lane zero
            sh <= shift_in(sh, `SFIO_W_SINGLE, lane_s);
            cnt <= cnt + 6'd1;
            if (cnt == 6'd7)
            begin
              opcode <= sh_next[7:0];
              CMD_OPCODE <= sh_next[7:0];
              is_read <= dec[12];
              aw <= dec[10:9];
              dw <= dec[8:7];
              dummy <= dec[6:1];
              cnt <= 6'd0;
              if (dec[0] && !QUAD_LANE_ENABLE_BIT)
                state <= ST_IGNORE;
              else if (dec[11])
                state <= ST_ADDR;
              else
              begin
                CMD_VALID <= 1'b1;
                CMD_ADDR <= 21'h000000;
                state <= (dec[6:1] != 6'd0) ? ST_DUMMY :
                  (dec[12] ? ST_DOUT : ST_DIN);
              end
            end
          end
          ST_ADDR:
          begin
            sh <= sh_next;
            cnt <= cnt + 6'd1;
            if (cnt == last_clk(`SFIO_ADDR_BITS, aw))
            begin
              // upper address bits beyond 2 megabytes are dropped
              CMD_ADDR <= sh_next[20:0] & erase_mask(opcode);
              CMD_VALID <= 1'b1;
              cnt <= 6'd0;
              state <= (dummy != 6'd0) ? ST_DUMMY :
                (is_read ? ST_DOUT : ST_DIN);
            end
          end
          ST_DUMMY:
          begin
            cnt <= cnt + 6'd1;
            if (cnt == dummy - 6'd1)
            begin
              cnt <= 6'd0;
              state <= is_read ? ST_DOUT : ST_DIN;
            end
          end
          ST_DIN:
          begin
            sh <= sh_next;
            cnt <= cnt + 6'd1;
            if (cnt == data_last)
            begin
              cnt <= 6'd0;
              // a program takes one page at most; later bytes are dropped
              if (!is_program || prog_cnt != `SFIO_PAGE_BYTES)
              begin
                prog_cnt <= prog_cnt + 9'h001;
                wr_pend <= sh_next[7:0];
                wr_pend_v <= 1'b1;
                if (wr_pend_v && !fifo_in_ready)
                  WR_OVERRUN <= 1'b1;
              end
            end
          end
          default:
          begin
            cnt <= cnt;
          end
        endcase
      end
      else if (go_fall && state == ST_DOUT)
      begin
        // read data moves on falling edges, msb first
        driving <= 1'b1;
        if (byte_out_need)
        begin
          rd_have <= 1'b0;
          obit <= data_last[2:0];
        end
        else
          obit <= obit - 3'd1;
        case (dw)
          `SFIO_W_DUAL: obyte <= {cur_byte[5:0], 2'b00};
          `SFIO_W_QUAD: obyte <= {cur_byte[3:0], 4'h0};
          default: obyte <= {cur_byte[6:0], 1'b0};
        endcase
      end
    end
  end

  // lane drivers: values change on falling edges only
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      DATA_LANE_ZERO_OUT <= 1'b0;
      DATA_LANE_ONE_OUT <= 1'b0;
      DATA_LANE_TWO_OUT <= 1'b0;
      DATA_LANE_THREE_OUT <= 1'b0;
    end
    else if (CE && go_fall && state == ST_DOUT && !cs_rise)
    begin
      case (dw)
        `SFIO_W_DUAL:
        begin
          DATA_LANE_ONE_OUT <= cur_byte[7];
          DATA_LANE_ZERO_OUT <= cur_byte[6];
        end
        `SFIO_W_QUAD:
        begin
          DATA_LANE_THREE_OUT <= cur_byte[7];
          DATA_LANE_TWO_OUT <= cur_byte[6];
          DATA_LANE_ONE_OUT <= cur_byte[5];
          DATA_LANE_ZERO_OUT <= cur_byte[4];
        end
        default:
        begin
          // single mode uses the dedicated serial output lane
          DATA_LANE_ONE_OUT <= cur_byte[7];
        end
      endcase
    end
  end

  // enables: only while selected, driving and not held
  wire drive_now = (state == ST_DOUT) && driving && !hold_act && !cs_rise &&
    !cs_fall && !filt[5];
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      DATA_LANE_ZERO_OE <= 1'b0;
      DATA_LANE_ONE_OE <= 1'b0;
      DATA_LANE_TWO_OE <= 1'b0;
      DATA_LANE_THREE_OE <= 1'b0;
    end
    else if (CE)
    begin
      DATA_LANE_ONE_OE <= drive_now;
      DATA_LANE_ZERO_OE <= drive_now && (dw != `SFIO_W_SINGLE);
      DATA_LANE_TWO_OE <= drive_now && (dw == `SFIO_W_QUAD);
      DATA_LANE_THREE_OE <= drive_now && (dw == `SFIO_W_QUAD);
    end
  end

  // write bytes toward the core pass an eight-word fifo
  sfio_fifo #(
    .W(`SFIO_FIFO_W),
    .D(`SFIO_FIFO_D),
    .AW(`SFIO_FIFO_AW)
  ) u_wr_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_data(wr_pend),
    .in_valid(wr_pend_v),
    .in_ready(fifo_in_ready),
    .out_data(WR_DATA),
    .out_valid(WR_VALID),
    .out_ready(WR_READY)
  );
endmodule // sfio_frontend

//--- sfio_defines.vh
`ifndef SFIO_DEFINES_VH
`define SFIO_DEFINES_VH

// opcodes the front end classifies; the two chip erase codes fall to its default class
`define SFIO_OP_READ 8'h03
`define SFIO_OP_FAST_READ 8'h0B
`define SFIO_OP_DUAL_OUT 8'h3B
`define SFIO_OP_QUAD_OUT 8'h6B
`define SFIO_OP_DUAL_IO 8'hBB
`define SFIO_OP_QUAD_IO 8'hEB
`define SFIO_OP_PROGRAM 8'h02
`define SFIO_OP_QUAD_PROGRAM 8'h32
`define SFIO_OP_ERASE_4K 8'h20
`define SFIO_OP_ERASE_32K 8'h52
`define SFIO_OP_ERASE_64K 8'hD8
`define SFIO_OP_CHIP_ERASE_A 8'hC7
`define SFIO_OP_CHIP_ERASE_B 8'h60
`define SFIO_OP_UNIQUE_ID 8'h4B
`define SFIO_OP_SEC_READ 8'h48
`define SFIO_OP_SEC_PROGRAM 8'h42
`define SFIO_OP_STATUS_1 8'h05
`define SFIO_OP_STATUS_2 8'h35
`define SFIO_OP_STATUS_3 8'h15
`define SFIO_OP_JEDEC_ID 8'h9F

// lane widths
`define SFIO_W_SINGLE 2'h0
`define SFIO_W_DUAL 2'h1
`define SFIO_W_QUAD 2'h2

// dummy clocks per read kind
`define SFIO_DUMMY_NONE 6'h00
`define SFIO_DUMMY_FAST 6'h08
`define SFIO_DUMMY_DUAL_IO 6'h04
`define SFIO_DUMMY_QUAD_IO 6'h06
`define SFIO_DUMMY_UID 6'h20

// array geometry
`define SFIO_ADDR_W 21
`define SFIO_ADDR_BITS 6'h18
`define SFIO_PAGE_BYTES 9'h100
`define SFIO_PAGES 14'h2000
`define SFIO_MASK_4K 21'h1FF000
`define SFIO_MASK_32K 21'h1F8000
`define SFIO_MASK_64K 21'h1F0000
`define SFIO_MASK_CHIP 21'h000000
`define SFIO_UID_BITS 7'h40
`define SFIO_SEC_REGS 2'h3
`define SFIO_SEC_BYTES 9'h100

// synchroniser reset levels {cs, sclk, lane3..lane0}
`define SFIO_SYNC_RST 6'h0F
`define SFIO_IDLE_BYTE 8'hFF

// fifo shape
`define SFIO_FIFO_W 8
`define SFIO_FIFO_D 8
`define SFIO_FIFO_AW 3

`endif

//--- sfio_fifo.v
`timescale 1ns/100ps
// small synchronous fifo, all outputs registered
module sfio_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output reg in_ready,
  output reg [W-1:0] out_data,
  output reg out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1]; // storage words
  reg [AW-1:0] wr_ptr; // next slot to fill
  reg [AW-1:0] rd_ptr; // slot behind out_data
  reg [AW:0] count; // words held, output stage included
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire [AW-1:0] next_rd = rd_ptr + {{(AW-1){1'b0}}, pop};

  // pointers, flags and registered head
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end
    else if (ce)
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      rd_ptr <= next_rd;
      count <= next_count;
      // flags from the next count keep full and empty honest
      in_ready <= (next_count != D[AW:0]);
      out_valid <= (next_count != {(AW+1){1'b0}});
      // head word: bypass when the push lands on the head slot
      if (push && (wr_ptr == next_rd))
        out_data <= in_data;
      else
        out_data <= mem[next_rd];
    end
  end
endmodule // sfio_fifo

//--- sfio_frontend_props.sv
`timescale 1ns/100ps
`include "sfio_defines.vh"
// port-level checks of the pin front end
module sfio_props (
  input wire CLK,
  input wire RST_N,
  input wire CS_N,
  input wire SCLK,
  input wire DATA_LANE_THREE_IN,
  input wire DATA_LANE_ZERO_OUT,
  input wire DATA_LANE_ONE_OUT,
  input wire DATA_LANE_ZERO_OE,
  input wire DATA_LANE_ONE_OE,
  input wire DATA_LANE_TWO_OE,
  input wire DATA_LANE_THREE_OE,
  input wire QUAD_LANE_ENABLE_BIT,
  input wire [7:0] CMD_OPCODE,
  input wire [20:0] CMD_ADDR,
  input wire CMD_VALID,
  input wire FRAME_END,
  input wire SELECTED,
  input wire RD_READY,
  input wire [7:0] WR_DATA,
  input wire WR_VALID,
  input wire WR_READY
);
  // one domain, so one clock and one disable for all
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire any_oe = DATA_LANE_ZERO_OE | DATA_LANE_ONE_OE | DATA_LANE_TWO_OE | DATA_LANE_THREE_OE;
  a_desel_quiet: assert property (CS_N [*8] |-> !any_oe)
    else $error("lane driven while deselected");
  a_frame_close: assert property (FRAME_END |-> ##[0:2] !SELECTED)
    else $error("frame stays open after close");
  a_select_edge: assert property ($rose(SELECTED) |-> !$past(CS_N) && !$past(CS_N, 2))
    else $error("frame opened without select low");
  // sync latency puts the pin fall 4 to 5 cycles back
  a_out_on_fall: assert property (DATA_LANE_ONE_OE && $past(DATA_LANE_ONE_OE)
    && $changed(DATA_LANE_ONE_OUT) |-> !$past(SCLK, 3) && $past(SCLK, 8))
    else $error("lane one moved off a falling edge");
  a_lane0_fall: assert property (DATA_LANE_ZERO_OE && $past(DATA_LANE_ZERO_OE)
    && $changed(DATA_LANE_ZERO_OUT) |-> !$past(SCLK, 3) && $past(SCLK, 8))
    else $error("lane zero moved off a falling edge");
  a_quad_gate: assert property (!QUAD_LANE_ENABLE_BIT |-> !DATA_LANE_TWO_OE && !DATA_LANE_THREE_OE)
    else $error("upper lanes driven without quad enable");
  a_upper_pair: assert property (DATA_LANE_TWO_OE |-> DATA_LANE_THREE_OE && DATA_LANE_ZERO_OE)
    else $error("quad lanes not driven together");
  a_hold_quiet: assert property ((!QUAD_LANE_ENABLE_BIT && !CS_N && !DATA_LANE_THREE_IN) [*6]
    |-> !DATA_LANE_ONE_OE)
    else $error("output driven during hold");
  a_erase_mask: assert property (CMD_VALID && CMD_OPCODE == `SFIO_OP_ERASE_64K
    |-> CMD_ADDR[15:0] == 16'h0000)
    else $error("block erase address not aligned");
  a_read_ready: assert property (CMD_VALID && CMD_OPCODE == `SFIO_OP_READ |=> RD_READY)
    else $error("read byte not requested");
  a_wr_stable: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_DATA))
    else $error("write byte changed before taken");
  c_cmd: cover property (CMD_VALID);
  c_frame: cover property (FRAME_END);
  c_quad: cover property (DATA_LANE_TWO_OE);
endmodule // sfio_props
bind sfio_frontend sfio_props u_props (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK),
  .DATA_LANE_THREE_IN(DATA_LANE_THREE_IN), .DATA_LANE_ZERO_OUT(DATA_LANE_ZERO_OUT),
  .DATA_LANE_ONE_OUT(DATA_LANE_ONE_OUT), .DATA_LANE_ZERO_OE(DATA_LANE_ZERO_OE),
  .DATA_LANE_ONE_OE(DATA_LANE_ONE_OE), .DATA_LANE_TWO_OE(DATA_LANE_TWO_OE),
  .DATA_LANE_THREE_OE(DATA_LANE_THREE_OE), .QUAD_LANE_ENABLE_BIT(QUAD_LANE_ENABLE_BIT),
  .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR), .CMD_VALID(CMD_VALID), .FRAME_END(FRAME_END),
  .SELECTED(SELECTED), .RD_READY(RD_READY), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID),
  .WR_READY(WR_READY));

//--- sfio_host.sv
`timescale 1ns/100ps
// host controller model: select, mode 0 clock, lanes
module sfio_host (
  input wire clk,
  input wire [3:0] dev_out,
  input wire [3:0] dev_oe,
  output reg cs_n,
  output reg sclk,
  output wire [3:0] lane_in
);
  reg [3:0] hv = 4'hC; // host lane values
  reg [3:0] hoe = 4'hC; // host lane enables, wp and hold held
  reg [3:0] last = 4'h0; // last wire level
  reg hold_n = 1'b1; // hold level outside quad
  // no pulls on the lanes, so a released lane shows the inverse of its last driven level
  assign lane_in = (dev_oe & dev_out) | (~dev_oe & hoe & hv) | (~dev_oe & ~hoe & ~last);
  always @(posedge clk)
    last <= ((dev_oe | hoe) & lane_in) | (~(dev_oe | hoe) & last);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0; // idles low, mode 0
  end
  // select falls with the clock still, a fresh edge each frame
  task sel;
    begin
      @(posedge clk);
      cs_n <= 1'b0;
      #100;
    end
  endtask
  task desel;
    begin
      #100;
      cs_n <= 1'b1;
      hoe <= 4'hC;
      #400;
    end
  endtask
  task hold(input v);
    begin
      hold_n = v;
      hv[3] <= v;
    end
  endtask
  // n clocks at lane width w, msb first; data lanes driven only when drv, wp and hold lanes always outside quad
  task xfer(input [1:0] w, input drv, input [31:0] tx, input [5:0] n, output [31:0] rx);
    integer i;
    begin
      rx = 32'h00000000;
      for (i = 0; i < n; i = i + 1)
      begin
        case (w) // lanes change while clock low
          2'h0: hv <= {hold_n, 1'b1, 1'b0, tx[31]};
          2'h1: hv <= {hold_n, 1'b1, tx[31:30]};
          default: hv <= tx[31:28];
        endcase
        hoe <= (w == 2'h2) ? {4{drv}} : (w == 2'h1) ? {2'h3, drv, drv} : {3'h6, drv};
        tx = tx << (3'h1 << w);
        #62.5 sclk <= 1'b1;
        case (w) // device lanes taken on the rise
          2'h0: rx = {rx[30:0], lane_in[1]};
          2'h1: rx = {rx[29:0], lane_in[1:0]};
          default: rx = {rx[27:0], lane_in};
        endcase
        #62.5 sclk <= 1'b0;
      end
    end
  endtask
endmodule // sfio_host

//--- sfio_frontend_tb_top.sv
`timescale 1ns/100ps
module sfio_frontend_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg qe = 1'b0;
  reg wr_ready = 1'b0;
  wire [3:0] lo, loe, li;
  wire cs_n, sclk, cmd_valid, wr_valid, wr_overrun;
  wire [7:0] cmd_opcode, wr_data;
  wire [20:0] cmd_addr;
  integer bad_count = 0, samples_checked = 0, n_cmd = 0, n_wr = 0, base, i;
  reg [7:0] wq [0:15]; // first bytes handed to the core
  reg [31:0] r, r2;
  always #5 clk = ~clk;
  sfio_host h (.clk(clk), .dev_out(lo), .dev_oe(loe), .cs_n(cs_n), .sclk(sclk), .lane_in(li));
  sfio_frontend uut (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .CS_N(cs_n), .SCLK(sclk),
    .DATA_LANE_ZERO_IN(li[0]), .DATA_LANE_ONE_IN(li[1]), .DATA_LANE_TWO_IN(li[2]),
    .DATA_LANE_THREE_IN(li[3]), .DATA_LANE_ZERO_OUT(lo[0]), .DATA_LANE_ONE_OUT(lo[1]),
    .DATA_LANE_TWO_OUT(lo[2]), .DATA_LANE_THREE_OUT(lo[3]), .DATA_LANE_ZERO_OE(loe[0]),
    .DATA_LANE_ONE_OE(loe[1]), .DATA_LANE_TWO_OE(loe[2]), .DATA_LANE_THREE_OE(loe[3]),
    .QUAD_LANE_ENABLE_BIT(qe), .CMD_OPCODE(cmd_opcode), .CMD_ADDR(cmd_addr),
    .CMD_VALID(cmd_valid), .FRAME_END(), .SELECTED(), .RD_DATA(8'hA5), .RD_VALID(1'b1),
    .RD_READY(), .WR_DATA(wr_data), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_OVERRUN(wr_overrun));
  // count commands and collect write bytes
  always @(posedge clk)
  begin
    if (cmd_valid)
      n_cmd <= n_cmd + 1;
    if (wr_valid && wr_ready)
    begin
      if (n_wr < 16)
        wq[n_wr] <= wr_data;
      n_wr <= n_wr + 1;
    end
  end
  task complete_run;
    begin
      if (bad_count == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input [8*8-1:0] nm);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wait_cmd(input integer k);
    integer t;
    begin
      for (t = 0; t < 60 && n_cmd < k; t = t + 1)
        @(posedge clk);
      if (n_cmd < k)
      begin
        bad_count = bad_count + 1;
        complete_run;
      end
    end
  endtask
  // opcode on lane zero, then address at width w
  task cmd(input [1:0] w, input [7:0] op, input [23:0] a);
    begin
      h.xfer(2'h0, 1'b1, {op, 24'h000000}, 6'h08, r);
      h.xfer(w, 1'b1, {a, 8'h00}, (w == 2'h0) ? 6'h18 : (w == 2'h1) ? 6'h0C : 6'h06, r);
    end
  endtask
  // select held low through reset opens no frame
  task s_no_edge;
    begin
      h.sel;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      cmd(2'h0, 8'h03, 24'h000000);
      repeat (20) @(posedge clk);
      chk(n_cmd, 0, "nocmd");
      h.desel;
    end
  endtask
  task s_read;
    begin
      h.sel;
      cmd(2'h0, 8'h03, 24'hFFFFFF);
      wait_cmd(1);
      chk(cmd_opcode, 8'h03, "opcode");
      chk(cmd_addr, 21'h1FFFFF, "addr");
      h.xfer(2'h0, 1'b0, 32'h0, 6'h10, r);
      chk(r[15:0], 16'hA5A5, "single");
      h.desel;
      chk(loe, 4'h0, "oe");
    end
  endtask
  task s_dual;
    begin
      h.sel;
      cmd(2'h1, 8'hBB, 24'h0A0B0C);
      wait_cmd(2);
      chk(cmd_addr, 21'h0A0B0C, "dualaddr");
      h.xfer(2'h1, 1'b0, 32'h0, 6'h04, r);
      h.xfer(2'h1, 1'b0, 32'h0, 6'h08, r);
      chk(r[15:0], 16'hA5A5, "dual");
      h.desel;
    end
  endtask
  // refused without quad enable; then lane three low through address
  task s_quad;
    begin
      h.sel;
      cmd(2'h2, 8'hEB, 24'h012345);
      repeat (30) @(posedge clk);
      chk(n_cmd, 2, "refused");
      h.desel;
      @(posedge clk);
      qe <= 1'b1;
      h.sel;
      cmd(2'h2, 8'hEB, 24'h012345);
      wait_cmd(3);
      chk(cmd_addr, 21'h012345, "quadaddr");
      h.xfer(2'h2, 1'b0, 32'h0, 6'h06, r);
      h.xfer(2'h2, 1'b0, 32'h0, 6'h04, r);
      chk(r[15:0], 16'hA5A5, "quad");
      h.desel;
      @(posedge clk);
      qe <= 1'b0;
    end
  endtask
  // clocks during hold must not advance the output
  task s_hold;
    begin
      h.sel;
      cmd(2'h0, 8'h03, 24'h000000);
      wait_cmd(4);
      h.xfer(2'h0, 1'b0, 32'h0, 6'h04, r);
      h.hold(1'b0);
      #150;
      chk(loe[1], 1'b0, "holdoe");
      h.xfer(2'h0, 1'b1, 32'h0, 6'h04, r2);
      h.hold(1'b1);
      #100;
      h.xfer(2'h0, 1'b0, 32'h0, 6'h0C, r2);
      chk({r[3:0], r2[11:0]}, 16'hA5A5, "holdrd");
      h.desel;
    end
  endtask
  // ten bytes with the core stalled: fifo fills, one is lost
  task s_fifo;
    begin
      h.sel;
      cmd(2'h0, 8'h02, 24'h000000);
      for (i = 0; i < 10; i = i + 1)
        h.xfer(2'h0, 1'b1, {8'h10 + i[7:0], 24'h000000}, 6'h08, r);
      #200;
      chk(wr_overrun, 1'b1, "overrun");
      h.desel;
      @(posedge clk);
      wr_ready <= 1'b1;
      repeat (20) @(posedge clk);
      for (i = 0; i < 8; i = i + 1)
        chk(wq[i], 8'h10 + i[7:0], "wrbyte");
    end
  endtask
  // one byte past a page is dropped
  task s_cap;
    begin
      base = n_wr;
      h.sel;
      cmd(2'h0, 8'h02, 24'h000100);
      for (i = 0; i < 257; i = i + 1)
        h.xfer(2'h0, 1'b1, {i[7:0], 24'h000000}, 6'h08, r);
      h.desel;
      repeat (10) @(posedge clk);
      chk(n_wr - base, 256, "pagecap");
    end
  endtask
  // each erase kind masks the address to its unit
  task s_erase;
    reg [7:0] op [0:4];
    reg [20:0] ea [0:4];
    begin
      op[0] = 8'h20;
      op[1] = 8'h52;
      op[2] = 8'hD8;
      op[3] = 8'hC7;
      op[4] = 8'h60;
      ea[0] = 21'h1FF000;
      ea[1] = 21'h1F8000;
      ea[2] = 21'h1F0000;
      ea[3] = 21'h000000;
      ea[4] = 21'h000000;
      for (i = 0; i < 5; i = i + 1)
      begin
        base = n_cmd;
        h.sel;
        if (i < 3)
          cmd(2'h0, op[i], 24'h1FFFFF);
        else
          h.xfer(2'h0, 1'b1, {op[i], 24'h000000}, 6'h08, r);
        wait_cmd(base + 1);
        chk(cmd_addr, ea[i], "erase");
        h.desel;
      end
    end
  endtask
  initial
  begin
    s_no_edge;
    s_read;
    s_dual;
    s_quad;
    s_hold;
    s_fifo;
    s_cap;
    s_erase;
    complete_run;
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // sfio_frontend_tb_top
